//--- core/hport_pkg.sv
// host port package: register map, field positions, reset values, states
// assumes one 25 MHz clock and a synchronous active high reset
// ============================================================
// Contract
// [R1] host never overlaps a polled read with a polled write
// [R2] local port registers complete at once, no completion check needed
// [R3] configuration words are big endian, byte 0 in bits 31..24
// [R4] 8/16-bit host writes gather into one word; reads split a word
// [R5] host wires its address and data msb to the port msb
// [R6] endian_select at 1 means no swap; swap_method then ignored
// [R7] endian_select at 0: swap_method 1 data invariant, 0 address invariant
// [R8] endian_select and swap_method both read 1 after reset
// [R9] data invariant reverses byte lanes, host byte 0 to device byte 3
// [R10] address invariant keeps each byte address, integers appear reversed
// [R11] port control register sits at offset 1EC
// [R12] interrupt status registers sit at offsets 10 and 18
// [R13] masks at 14 and 1C; mask 1 passes bit to output, 0 blocks
// [R14] status bits record events even while masked
// [R15] both status registers show the two group indicator bits
// [R16] writing 1 clears a status bit, writing 0 leaves it
// [R17] polled access only while control polled-mode bit is 1
// [R18] access before completion is aborted and raises invalid_access_irq
// [R19] polled_done_flag shows at bits 7, 15, 23, 31 of polled status
// [R20] interrupt output high while any status bit and its mask are set
// [R21] 16-bit data invariant swaps bytes in halves and exchanges halves
package hport_pkg;
  // ==========================================================
  // widths
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  localparam int WORD_W = 32;
  localparam int EVT_W  = 30;
  localparam int CTRL_W = 3;
  localparam int SYNC_W = 4 + ADDR_W + DATA_W;

  // ==========================================================
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT0 = 9'h010;  // [R12]
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK0 = 9'h014;  // [R13]
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT1 = 9'h018;  // [R12]
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK1 = 9'h01C;  // [R13]
  localparam logic [ADDR_W-1:0] OFS_PORT_CTRL = 9'h1EC;  // [R11]
  localparam logic [ADDR_W-1:0] OFS_POLL_STAT = 9'h1F0;
  localparam logic [ADDR_W-1:0] OFS_POLL_HOLD = 9'h1F4;
  localparam logic [ADDR_W-1:0] OFS_SOFT_RST  = 9'h1F8;

  // ==========================================================
  // fields and reset values
  localparam int                CTRL_ENDIAN_BIT = 0;
  localparam int                CTRL_SWAP_BIT   = 1;
  localparam int                CTRL_POLL_BIT   = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET      = 3'h3;  // [R8]
  localparam logic [WORD_W-1:0] POLL_DONE_MASK  = 32'h8080_8080;  // [R19]
  localparam int                SOFT_RST_BIT    = 0;
  localparam int                INVALID_BIT     = 0;
  localparam logic [1:0]        LANE0           = 2'h0;
  localparam logic [1:0]        LANE_LAST       = 2'h3;
  localparam logic [SYNC_W-1:0] SYNC_IDLE       = {3'h7, {(SYNC_W-3){1'b0}}};

  // ==========================================================
  // access sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RD   = 3'h2,
    ST_WR   = 3'h4
  } acc_state_t;

  // word aligned register address
  function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W-1:0] a);
    word_addr = {a[ADDR_W-1:2], 2'h0};
  endfunction : word_addr
endpackage : hport_pkg

//--- core/byte_lane_swap.sv
// byte lane mapping between host order and big endian device order
// assumes host order places host byte k in bits 31-8k..24-8k
module byte_lane_swap (
  // word in and out
  input  wire logic [hport_pkg::WORD_W-1:0] word_in,
  output logic      [hport_pkg::WORD_W-1:0] word_out,
  // mode
  input  wire logic                         endian_select,
  input  wire logic                         swap_method,
  input  wire logic                         wide
);
  import hport_pkg::*;

  // ==========================================================
  // mapping is its own inverse, so one instance serves each direction
  always_comb begin
    if (endian_select) begin
      word_out = word_in;  // [R6] [R3]
    end else if (swap_method) begin
      // full reversal; for 16-bit this is swap in halves plus half exchange
      word_out = {word_in[7:0], word_in[15:8], word_in[23:16], word_in[31:24]};  // [R9] [R21]
    end else if (wide) begin
      // little endian host puts the lower address byte on the low pins
      word_out = {word_in[23:16], word_in[31:24], word_in[7:0], word_in[15:8]};  // [R10]
    end else begin
      word_out = word_in;  // [R10] [R7]
    end
  end
endmodule : byte_lane_swap

//--- core/irq_status_bank.sv
// two interrupt status and mask register pairs driving one output
// assumes event inputs are single-cycle or level pulses on the same clock
module irq_status_bank (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // register write
  input  wire logic                         we,
  input  wire logic [hport_pkg::ADDR_W-1:0] waddr,
  input  wire logic [hport_pkg::WORD_W-1:0] wdata,
  // events
  input  wire logic [hport_pkg::EVT_W-1:0]  evt0,
  input  wire logic [hport_pkg::EVT_W-1:0]  evt1,
  // read back and output
  output logic      [hport_pkg::WORD_W-1:0] stat0_word,
  output logic      [hport_pkg::WORD_W-1:0] stat1_word,
  output logic      [hport_pkg::WORD_W-1:0] mask0_word,
  output logic      [hport_pkg::WORD_W-1:0] mask1_word,
  output logic                              irq
);
  import hport_pkg::*;

  logic [EVT_W-1:0] st0_r, st0_nxt, st1_r, st1_nxt;
  logic [EVT_W-1:0] mk0_r, mk0_nxt, mk1_r, mk1_nxt;
  logic [EVT_W-1:0] clr0, clr1;
  logic             pend0, pend1, irq_r, irq_nxt;

  // ==========================================================
  // next state: an event in the clearing cycle survives the clear
  always_comb begin
    clr0    = (we && waddr == OFS_IRQ_STAT0) ? wdata[EVT_W-1:0] : '0;  // [R16]
    clr1    = (we && waddr == OFS_IRQ_STAT1) ? wdata[EVT_W-1:0] : '0;  // [R16]
    st0_nxt = (st0_r & ~clr0) | evt0;  // [R14]
    st1_nxt = (st1_r & ~clr1) | evt1;  // [R14]
    mk0_nxt = (we && waddr == OFS_IRQ_MASK0) ? wdata[EVT_W-1:0] : mk0_r;
    mk1_nxt = (we && waddr == OFS_IRQ_MASK1) ? wdata[EVT_W-1:0] : mk1_r;
    pend0   = |(st0_r & mk0_r);  // [R13]
    pend1   = |(st1_r & mk1_r);  // [R13]
    irq_nxt = pend0 | pend1;  // [R20]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st0_r <= '0;
      st1_r <= '0;
      mk0_r <= '0;
      mk1_r <= '0;
      irq_r <= 1'b0;
    end else begin
      st0_r <= st0_nxt;
      st1_r <= st1_nxt;
      mk0_r <= mk0_nxt;
      mk1_r <= mk1_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ==========================================================
  // read back: group indicators on top of both status words
  assign stat0_word = {pend0, pend1, st0_r};  // [R15]
  assign stat1_word = {pend0, pend1, st1_r};  // [R15]
  assign mask0_word = WORD_W'(mk0_r);
  assign mask1_word = WORD_W'(mk1_r);
  assign irq        = irq_r;

  masked_record_a: assert property (@(posedge clk) disable iff (rst)  // [R14]
    (|(evt0 & ~mk0_r)) |=> (st0_r & $past(evt0)) == $past(evt0))
    else $error("masked event not recorded");
  w1c_clear_a: assert property (@(posedge clk) disable iff (rst)  // [R16]
    (we && waddr == OFS_IRQ_STAT1 && wdata[4] && !evt1[4]) |=> !st1_r[4])
    else $error("status bit not cleared by write of one");
  w0_keep_a: assert property (@(posedge clk) disable iff (rst)  // [R16]
    (we && waddr == OFS_IRQ_STAT0 && !wdata[3] && st0_r[3]) |=> st0_r[3])
    else $error("status bit lost on write of zero");
  irq_follow_a: assert property (@(posedge clk) disable iff (rst)  // [R20]
    ((|(st0_r & mk0_r)) || (|(st1_r & mk1_r))) |=> irq)
    else $error("interrupt output missing");
  irq_quiet_a: assert property (@(posedge clk) disable iff (rst)  // [R13]
    (!(|(st0_r & mk0_r)) && !(|(st1_r & mk1_r))) |=> !irq)
    else $error("interrupt output without unmasked source");
  group_flag_a: assert property (@(posedge clk) disable iff (rst)  // [R15]
    (evt1[4] && mk1_r[4] && !we) |=> stat0_word[WORD_W-2] && stat1_word[WORD_W-2])
    else $error("group indicator not shown");
endmodule : irq_status_bank

//--- core/host_port.sv
// parallel host port: byte gathering, endian swap, polled access, interrupts
// assumes host pins are asynchronous and the configuration side shares REF_CLK
module host_port (
  // clock and reset
  input  wire logic                         REF_CLK,
  input  wire logic                         RST,
  // host bus pins
  input  wire logic                         CS_N,
  input  wire logic                         RD_N,
  input  wire logic                         WR_N,
  input  wire logic                         BUS16,
  input  wire logic [hport_pkg::ADDR_W-1:0] HA,
  input  wire logic [hport_pkg::DATA_W-1:0] HD_I,
  output logic      [hport_pkg::DATA_W-1:0] HD_O,
  output logic                              HD_OE_N,
  output logic                              HRDY,
  // configuration register side
  output logic                              CFG_REQ,
  output logic                              CFG_WE,
  output logic      [hport_pkg::ADDR_W-1:0] CFG_ADDR,
  output logic      [hport_pkg::WORD_W-1:0] CFG_WDATA,
  input  wire logic                         CFG_ACK,
  input  wire logic [hport_pkg::WORD_W-1:0] CFG_RDATA,
  // events, interrupt, soft reset
  input  wire logic [hport_pkg::EVT_W-1:0]  EVT0,
  input  wire logic [hport_pkg::EVT_W-1:0]  EVT1,
  output logic                              IRQ,
  output logic                              SOFT_RST
);
  import hport_pkg::*;

  // ==========================================================
  // lane helpers
  function automatic logic [WORD_W-1:0] put_lane(input logic [WORD_W-1:0] w,
                                                 input logic [1:0]        a,
                                                 input logic [DATA_W-1:0] d,
                                                 input logic              wd);
    logic [WORD_W-1:0] r;
    r = w;
    if (wd) begin
      if (a[1]) r[15:0] = d;
      else      r[31:16] = d;
    end else begin
      unique case (a)
        2'h0: r[31:24] = d[7:0];  // [R3]
        2'h1: r[23:16] = d[7:0];
        2'h2: r[15:8]  = d[7:0];
        2'h3: r[7:0]   = d[7:0];
      endcase
    end
    put_lane = r;
  endfunction : put_lane

  function automatic logic [DATA_W-1:0] get_lane(input logic [WORD_W-1:0] w,
                                                 input logic [1:0]        a,
                                                 input logic              wd);
    logic [DATA_W-1:0] r;
    r = '0;
    if (wd) begin
      r = a[1] ? w[15:0] : w[31:16];
    end else begin
      unique case (a)
        2'h0: r[7:0] = w[31:24];
        2'h1: r[7:0] = w[23:16];
        2'h2: r[7:0] = w[15:8];
        2'h3: r[7:0] = w[7:0];
      endcase
    end
    get_lane = r;
  endfunction : get_lane

  function automatic logic is_local(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = word_addr(a);
    is_local = (w == OFS_IRQ_STAT0) || (w == OFS_IRQ_MASK0) ||
               (w == OFS_IRQ_STAT1) || (w == OFS_IRQ_MASK1) ||
               (w == OFS_PORT_CTRL) || (w == OFS_POLL_STAT) ||
               (w == OFS_POLL_HOLD) || (w == OFS_SOFT_RST);
  endfunction : is_local

  // ==========================================================
  // pin synchroniser: three stages, a bit moves once stages two and three agree
  logic [SYNC_W-1:0] s1_r, s2_r, s3_r, pins_r, pins_nxt;
  logic              cs_n_q, rd_n_q, wr_n_q, wide_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] data_q;

  always_comb begin
    pins_nxt = (s3_r & ~(s2_r ^ s3_r)) | (pins_r & (s2_r ^ s3_r));
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      s1_r   <= SYNC_IDLE;
      s2_r   <= SYNC_IDLE;
      s3_r   <= SYNC_IDLE;
      pins_r <= SYNC_IDLE;
    end else begin
      s1_r   <= {CS_N, RD_N, WR_N, BUS16, HA, HD_I};
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      pins_r <= pins_nxt;
    end
  end

  assign {cs_n_q, rd_n_q, wr_n_q, wide_q, addr_q, data_q} = pins_r;

  // ==========================================================
  // access sequencer
  acc_state_t        state_r, state_nxt;
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [WORD_W-1:0] hbuf_r, hbuf_nxt, hold_r, hold_nxt, wdata_r, wdata_nxt;
  logic [ADDR_W-1:0] caddr_r, caddr_nxt;
  logic [DATA_W-1:0] hd_o_r, hd_o_nxt;
  logic              req_r, req_nxt, we_r, we_nxt, done_r, done_nxt;
  logic              oe_n_r, oe_n_nxt, invalid_r, invalid_nxt, soft_r, soft_nxt;
  logic              rd_prev_r, wr_prev_r, rd_lvl, wr_lvl, acc_rd, acc_wr;
  logic              busy, polled, cfg_sel, last_lane, ack_rd, loc_we;
  logic [WORD_W-1:0] dev_wdata, rd_src, rd_host, local_word;
  logic [WORD_W-1:0] stat0_w, stat1_w, mask0_w, mask1_w;
  logic [EVT_W-1:0]  evt0_in;

  assign rd_lvl    = !cs_n_q && !rd_n_q;
  assign wr_lvl    = !cs_n_q && !wr_n_q;
  assign acc_rd    = rd_lvl && !rd_prev_r;
  assign acc_wr    = wr_lvl && !wr_prev_r;
  assign busy      = state_r != ST_IDLE;
  assign polled    = ctrl_r[CTRL_POLL_BIT];
  assign cfg_sel   = !is_local(addr_q);
  assign last_lane = addr_q[1:0] == LANE_LAST || (wide_q && addr_q[1]);  // [R4]
  assign ack_rd    = state_r == ST_RD && CFG_ACK;

  // local registers answer in the same cycle; no completion check needed
  always_comb begin
    unique case (word_addr(addr_q))
      OFS_IRQ_STAT0: local_word = stat0_w;
      OFS_IRQ_MASK0: local_word = mask0_w;
      OFS_IRQ_STAT1: local_word = stat1_w;
      OFS_IRQ_MASK1: local_word = mask1_w;
      OFS_PORT_CTRL: local_word = WORD_W'(ctrl_r);
      OFS_POLL_STAT: local_word = done_r ? POLL_DONE_MASK : '0;  // [R19]
      OFS_POLL_HOLD: local_word = hold_r;
      default:       local_word = '0;
    endcase
  end

  assign rd_src = (acc_rd && !cfg_sel) ? local_word : (ack_rd ? CFG_RDATA : hold_r);

  byte_lane_swap wr_swap (
    .word_in       (hbuf_nxt),
    .word_out      (dev_wdata),
    .endian_select (ctrl_r[CTRL_ENDIAN_BIT]),
    .swap_method   (ctrl_r[CTRL_SWAP_BIT]),
    .wide          (wide_q)
  );

  byte_lane_swap rd_swap (
    .word_in       (rd_src),
    .word_out      (rd_host),
    .endian_select (ctrl_r[CTRL_ENDIAN_BIT]),
    .swap_method   (ctrl_r[CTRL_SWAP_BIT]),
    .wide          (wide_q)
  );

  always_comb begin
    state_nxt   = state_r;
    ctrl_nxt    = ctrl_r;
    hbuf_nxt    = hbuf_r;
    hold_nxt    = hold_r;
    wdata_nxt   = wdata_r;
    caddr_nxt   = caddr_r;
    hd_o_nxt    = hd_o_r;
    req_nxt     = req_r;
    we_nxt      = we_r;
    done_nxt    = done_r;
    invalid_nxt = 1'b0;
    soft_nxt    = 1'b0;
    loc_we      = 1'b0;
    oe_n_nxt    = !rd_lvl;
    // completion of a configuration access
    if (busy && CFG_ACK) begin
      state_nxt = ST_IDLE;
      req_nxt   = 1'b0;
      done_nxt  = 1'b1;  // [R19]
      if (ack_rd) begin
        hold_nxt = CFG_RDATA;
        if (!polled) hd_o_nxt = get_lane(rd_host, LANE0, wide_q);
      end
    end
    // a configuration access while busy is dropped; started work runs on
    if (acc_wr) begin
      if (cfg_sel && busy) begin
        invalid_nxt = polled;  // [R18] [R17] [R1]
      end else begin
        hbuf_nxt = put_lane(hbuf_r, addr_q[1:0], data_q, wide_q);  // [R4]
        if (last_lane && cfg_sel) begin
          state_nxt = ST_WR;
          req_nxt   = 1'b1;
          we_nxt    = 1'b1;
          caddr_nxt = word_addr(addr_q);
          wdata_nxt = dev_wdata;  // [R4]
          done_nxt  = 1'b0;
        end else if (last_lane) begin
          loc_we = 1'b1;  // [R2]
          if (word_addr(addr_q) == OFS_PORT_CTRL) ctrl_nxt = dev_wdata[CTRL_W-1:0];
          if (word_addr(addr_q) == OFS_SOFT_RST) soft_nxt = dev_wdata[SOFT_RST_BIT];
        end
      end
    end
    if (acc_rd) begin
      if (cfg_sel && busy) begin
        invalid_nxt = polled;  // [R18] [R1]
      end else if (cfg_sel && addr_q[1:0] == LANE0) begin
        state_nxt = ST_RD;
        req_nxt   = 1'b1;
        we_nxt    = 1'b0;
        caddr_nxt = word_addr(addr_q);
        done_nxt  = 1'b0;
        hd_o_nxt  = '0;  // first read only launches the access
      end else begin
        hd_o_nxt = get_lane(rd_host, addr_q[1:0], wide_q);  // [R4] [R2]
        // reading status or holding clears the flag unless it sets now
        if (!cfg_sel && addr_q[1:0] == LANE0 && !(busy && CFG_ACK) &&
            (word_addr(addr_q) == OFS_POLL_STAT || word_addr(addr_q) == OFS_POLL_HOLD)) begin
          done_nxt = 1'b0;
        end
      end
    end
    if (soft_r) begin
      hbuf_nxt = '0;
      hold_nxt = '0;
      done_nxt = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_r   <= ST_IDLE;
      ctrl_r    <= CTRL_RESET;  // [R8]
      hbuf_r    <= '0;
      hold_r    <= '0;
      wdata_r   <= '0;
      caddr_r   <= '0;
      hd_o_r    <= '0;
      req_r     <= 1'b0;
      we_r      <= 1'b0;
      done_r    <= 1'b0;
      oe_n_r    <= 1'b1;
      invalid_r <= 1'b0;
      soft_r    <= 1'b0;
      rd_prev_r <= 1'b0;
      wr_prev_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      ctrl_r    <= ctrl_nxt;
      hbuf_r    <= hbuf_nxt;
      hold_r    <= hold_nxt;
      wdata_r   <= wdata_nxt;
      caddr_r   <= caddr_nxt;
      hd_o_r    <= hd_o_nxt;
      req_r     <= req_nxt;
      we_r      <= we_nxt;
      done_r    <= done_nxt;
      oe_n_r    <= oe_n_nxt;
      invalid_r <= invalid_nxt;
      soft_r    <= soft_nxt;
      rd_prev_r <= rd_lvl;
      wr_prev_r <= wr_lvl;
    end
  end

  // ==========================================================
  // interrupt bank; accesses aborted in polled mode feed the invalid access bit
  assign evt0_in = EVT0 | (EVT_W'(invalid_r) << INVALID_BIT);  // [R18]

  irq_status_bank irq_bank (
    .clk        (REF_CLK),
    .rst        (RST),
    .we         (loc_we),
    .waddr      (word_addr(addr_q)),
    .wdata      (dev_wdata),
    .evt0       (evt0_in),
    .evt1       (EVT1),
    .stat0_word (stat0_w),
    .stat1_word (stat1_w),
    .mask0_word (mask0_w),
    .mask1_word (mask1_w),
    .irq        (IRQ)
  );

  // ==========================================================
  // outputs
  assign HD_O      = hd_o_r;
  assign HD_OE_N   = oe_n_r;
  assign HRDY      = !busy;
  assign CFG_REQ   = req_r;
  assign CFG_WE    = we_r;
  assign CFG_ADDR  = caddr_r;
  assign CFG_WDATA = wdata_r;
  assign SOFT_RST  = soft_r;

  // ==========================================================
  // checks
  ctrl_reset_a: assert property (@(posedge REF_CLK)  // [R8]
    $past(RST) && !RST |-> ctrl_r[CTRL_ENDIAN_BIT] && ctrl_r[CTRL_SWAP_BIT])
    else $error("control bits not one after reset");
  done_set_a: assert property (@(posedge REF_CLK) disable iff (RST)  // [R19]
    (busy && CFG_ACK && !soft_r) |=> done_r && !busy)
    else $error("completion flag not set on acknowledge");
  abort_keep_a: assert property (@(posedge REF_CLK) disable iff (RST)  // [R18]
    (acc_wr && cfg_sel && busy && !CFG_ACK) |=> $stable(CFG_ADDR) && $stable(CFG_WDATA))
    else $error("aborted access changed the pending request");
  abort_flag_a: assert property (@(posedge REF_CLK) disable iff (RST)  // [R18]
    (acc_rd && cfg_sel && busy && polled) |=> invalid_r ##1 stat0_w[INVALID_BIT])
    else $error("invalid access not reported");
  polled_gate_a: assert property (@(posedge REF_CLK) disable iff (RST)  // [R17]
    !polled |=> !invalid_r)
    else $error("invalid access raised outside polled mode");
  launch_last_a: assert property (@(posedge REF_CLK) disable iff (RST)  // [R4]
    (acc_wr && cfg_sel && !busy) |=> (CFG_REQ && CFG_WE) == $past(last_lane))
    else $error("write launched on wrong lane");
  big_pass_a: assert property (@(posedge REF_CLK) disable iff (RST)  // [R6]
    (acc_wr && cfg_sel && !busy && last_lane && ctrl_r[CTRL_ENDIAN_BIT])
      |=> CFG_WDATA == $past(hbuf_nxt))
    else $error("big endian write was swapped");
  data_inv_a: assert property (@(posedge REF_CLK) disable iff (RST)  // [R9]
    (acc_wr && cfg_sel && !busy && last_lane && !ctrl_r[CTRL_ENDIAN_BIT] && ctrl_r[CTRL_SWAP_BIT])
      |=> CFG_WDATA[7:0] == $past(hbuf_nxt[31:24]))
    else $error("data invariant lanes not reversed");
  local_fast_a: assert property (@(posedge REF_CLK) disable iff (RST)  // [R2]
    (acc_wr && !cfg_sel && !busy) |=> !busy && !CFG_REQ)
    else $error("local register access went to configuration side");
endmodule : host_port

//--- tb/cfg_side_model.sv
// config side model: req/ack responder with a word store
// assumes the port's clock, one access at a time
module cfg_side_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // access
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [8:0]  addr,
  input  wire logic [31:0] wdata,
  output logic             ack,
  output logic      [31:0] rdata,
  // pacing and record
  input  wire logic        slow,
  output int               nwr,
  output logic      [31:0] last_w
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [int];
  int          cnt;
  // ============================================================
  // slow mode outlasts a host access; rdata toggles when not valid
  always @(posedge clk) begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if (rst) begin
      cnt <= 0;
      nwr <= 0;
      rdata <= 32'h0;
    end else if (req && !ack) begin
      cnt <= cnt + 1;
      if (cnt >= (slow ? 60 : 2)) begin
        ack <= 1'b1;
        cnt <= 0;
        if (we) begin
          mem[addr] = wdata;
          last_w <= wdata;
          nwr <= nwr + 1;
        end else begin
          rdata <= mem.exists(addr) ? mem[addr] : 32'h0;
        end
      end
    end
  end
endmodule : cfg_side_model

//--- tb/host_port_endian_and_interrupts_tb_top.sv
// testbench: host bus driver, endian sweep, interrupts, polled access
// assumes the config side model shares REF_CLK
module host_port_endian_and_interrupts_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import hport_pkg::*;
  logic REF_CLK = 1'b0, RST = 1'b1, CS_N = 1'b1, RD_N = 1'b1, WR_N = 1'b1, BUS16 = 1'b0;
  logic HD_OE_N, HRDY, CFG_REQ, CFG_WE, CFG_ACK, IRQ, SOFT_RST, slow = 1'b0, es, sm;
  logic [8:0]  HA = 9'h000, CFG_ADDR, a;
  logic [15:0] HD_I = 16'h0000, HD_O, r;
  logic [29:0] EVT0 = 30'h0, EVT1 = 30'h0;
  logic [31:0] CFG_WDATA, CFG_RDATA, last_w, h, q;
  int          mismatches = 0, num_checks = 0, nwr, n0, nsoft = 0;
  always #20 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) if (SOFT_RST === 1'b1) nsoft++;
  // host msb wired to port msb
  host_port dut (.REF_CLK, .RST, .CS_N, .RD_N, .WR_N, .BUS16, .HA, .HD_I, .HD_O, .HD_OE_N,
    .HRDY, .CFG_REQ, .CFG_WE, .CFG_ADDR, .CFG_WDATA, .CFG_ACK, .CFG_RDATA, .EVT0,
    .EVT1, .IRQ, .SOFT_RST);
  cfg_side_model peer (.clk(REF_CLK), .rst(RST), .req(CFG_REQ), .we(CFG_WE), .addr(CFG_ADDR),
    .wdata(CFG_WDATA), .ack(CFG_ACK), .rdata(CFG_RDATA), .slow(slow), .nwr(nwr), .last_w(last_w));
  // ============================================================
  // expected device word for a host word
  function automatic logic [31:0] swp(input logic [31:0] w, input logic e, s, wd);
    if (e) return w;
    if (s) return {w[7:0], w[15:8], w[23:16], w[31:24]};
    return wd ? {w[23:16], w[31:24], w[7:0], w[15:8]} : w;
  endfunction : swp
  task automatic chk(input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  // ============================================================
  // one strobe, held well past the three-flop sync
  task automatic acc(input logic w, input logic [8:0] ad, input logic [15:0] d);
    @(posedge REF_CLK);
    {CS_N, WR_N, RD_N} <= {1'b0, !w, w};
    HA <= ad;
    HD_I <= d;
    repeat (8) @(posedge REF_CLK);
    #1 r = HD_O;
    chk(HD_OE_N, w);
    @(posedge REF_CLK);
    {CS_N, RD_N, WR_N} <= 3'h7;
    repeat (6) @(posedge REF_CLK);
  endtask : acc
  task automatic xw(input logic w, input logic [8:0] ad, input logic [31:0] hw,
                    output logic [31:0] got);
    got = 32'h0;
    for (int k = 0; k < (BUS16 ? 2 : 4); k++) begin
      if (BUS16) begin
        acc(w, ad + 9'(2 * k), hw[31-16*k -: 16]);
        got[31-16*k -: 16] = r;
      end else begin
        acc(w, ad + 9'(k), {8'h00, hw[31-8*k -: 8]});
        got[31-8*k -: 8] = r[7:0];
      end
    end
  endtask : xw
  // no new access until the previous one ends
  task automatic wait_rdy;
    for (int i = 0; i < 300 && HRDY !== 1'b1; i++) @(posedge REF_CLK);
    #1 chk(HRDY, 1'b1);
  endtask : wait_rdy
  task automatic set_ctrl(input logic [2:0] v);
    @(posedge REF_CLK);
    xw(1'b1, OFS_PORT_CTRL, swp({29'h0, v}, es, sm, BUS16), q);
    {sm, es} = v[1:0];
  endtask : set_ctrl
  // ============================================================
  initial begin
    void'($urandom(66));
    {es, sm} = 2'h3;
    repeat (16) @(posedge REF_CLK);
    RST <= 1'b0;
    xw(1'b0, OFS_PORT_CTRL, 32'h0, q);
    chk(q, 32'h3);
    for (int m = 0; m < 6; m++) begin
      BUS16 <= m[0];
      set_ctrl(m < 2 ? 3'h3 : (m < 4 ? 3'h2 : 3'h0));
      h = (m == 0) ? 32'h0102_0304 : $urandom;
      a = 9'h040 + 9'(4 * ($urandom % 16));
      xw(1'b1, a, h, q);
      wait_rdy();
      chk(last_w, swp(h, es, sm, BUS16));
      chk(CFG_ADDR, a);
      acc(1'b0, a, 16'h0);
      wait_rdy();
      xw(1'b0, OFS_POLL_HOLD, 32'h0, q);
      chk(q, h);
    end
    BUS16 <= 1'b0;
    set_ctrl(3'h3);
    xw(1'b1, OFS_IRQ_MASK0, 32'h0, q);
    EVT0 <= 30'h28;
    @(posedge REF_CLK);
    EVT0 <= 30'h0;
    repeat (3) @(posedge REF_CLK);
    chk(IRQ, 1'b0);
    xw(1'b0, OFS_IRQ_STAT0, 32'h0, q);
    chk(q, 32'h28);
    xw(1'b1, OFS_IRQ_MASK0, 32'h20, q);
    chk(IRQ, 1'b1);
    xw(1'b0, OFS_IRQ_STAT1, 32'h0, q);
    chk(q, 32'h8000_0000);
    xw(1'b1, OFS_IRQ_STAT0, 32'h20, q);
    chk(IRQ, 1'b0);
    xw(1'b1, OFS_IRQ_MASK1, 32'h10, q);
    EVT1 <= 30'h10;
    @(posedge REF_CLK);
    EVT1 <= 30'h0;
    xw(1'b0, OFS_IRQ_STAT0, 32'h0, q);
    chk(q, 32'h4000_0008);
    xw(1'b1, OFS_IRQ_STAT1, 32'h10, q);
    chk(IRQ, 1'b0);
    set_ctrl(3'h7);
    n0 = nwr;
    slow <= 1'b1;
    xw(1'b1, 9'h080, 32'hA5A5_5A5A, q);
    acc(1'b0, OFS_POLL_STAT + 9'h3, 16'h0);
    chk(r, 16'h0000);
    acc(1'b1, 9'h083, 16'h0011);
    wait_rdy();
    chk(nwr, n0 + 1);
    acc(1'b0, OFS_POLL_STAT, 16'h0);
    chk(r, 16'h0080);
    xw(1'b0, OFS_IRQ_STAT0, 32'h0, q);
    chk(q[0], 1'b1);
    xw(1'b1, OFS_SOFT_RST, 32'h1, q);
    chk(nsoft, 1);
    stop_test();
  end
  initial begin
    repeat (30000) @(posedge REF_CLK);
    mismatches++;
    stop_test();
  end
endmodule : host_port_endian_and_interrupts_tb_top
